// ===== common/exec_pkg.sv
// Purpose: Shared constants and types for the execution unit
// Assumes: 8-bit data path, 16-bit program words
// Notes: Opcode codes are internal to the decoder link
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int DEF_ADDR_W = 9;
  localparam int DEF_PC_W = 13;
  localparam int PTR_LOW_W = 8;
  localparam int FLAG_W = 6;
  localparam int FLG_CARRY = 0;
  localparam int FLG_AUX = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_WRAP = 3;
  localparam int FLG_SIGNED = 4;
  localparam int FLG_CHAIN_ZERO = 5;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_SET_BYTE,
    OP_SET_BIT,
    OP_FAR_CLEAR_MEM,
    OP_FAR_CLEAR_BIT,
    OP_INC_SKIP_IF_ZERO,
    OP_INC_TO_ACC_SKIP_IF_ZERO,
    OP_BIT_SKIP_IF_NONZERO,
    OP_BIT_SKIP_IF_ZERO,
    OP_SKIP_IF_NONZERO,
    OP_SKIP_IF_ZERO,
    OP_COPY_SKIP_IF_ZERO,
    OP_SUBTRACT_TO_ACC,
    OP_SUBTRACT_INTO_MEM,
    OP_SUBTRACT_IMM,
    OP_NIBBLE_EXCHANGE_MEM,
    OP_NIBBLE_EXCHANGE_TO_ACC,
    OP_TABLE_READ_PAGED,
    OP_TABLE_READ_LAST_PAGE,
    OP_PREINC_TABLE_READ_PAGED,
    OP_PREINC_TABLE_READ_LAST,
    OP_XOR_TO_ACC,
    OP_XOR_INTO_MEM,
    OP_XOR_IMM,
    OP_FAR_ADD_CARRY_TO_ACC,
    OP_FAR_ADD_CARRY_TO_MEM,
    OP_FAR_ADD_TO_ACC,
    OP_FAR_ADD_TO_MEM,
    OP_FAR_AND_TO_ACC,
    OP_FAR_AND_TO_MEM
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DUMMY,
    ST_TABLE_FETCH
  } st_t;
endpackage

// ===== logic/arith_core.sv
// Purpose: 8-bit adder and subtractor with status flags
// Assumes: Subtract means lhs minus rhs with no borrow in
// Notes: Carry out is the inverted borrow when subtracting
`timescale 1ns/1ns
`default_nettype none
module arith_core (
  input wire logic [7:0] lhs_in,
  input wire logic [7:0] rhs_in,
  input wire logic carry_in,
  input wire logic subtract_in,
  output logic [7:0] result_out,
  output logic carry_out,
  output logic aux_out,
  output logic wrap_out,
  output logic signed_out,
  output logic zero_out
);
  logic [7:0] rhs_eff;
  logic cin_eff;
  logic [4:0] low_sum;
  logic [8:0] sum;

  // Two's complement subtract reuses the adder
  assign rhs_eff = subtract_in ? ~rhs_in : rhs_in;
  assign cin_eff = subtract_in ? 1'b1 : carry_in;
  assign low_sum = {1'b0, lhs_in[3:0]} + {1'b0, rhs_eff[3:0]} + {4'h0, cin_eff};
  assign sum = {1'b0, lhs_in} + {1'b0, rhs_eff} + {8'h00, cin_eff};
  assign result_out = sum[7:0];
  assign carry_out = sum[8];
  assign aux_out = low_sum[4];
  assign wrap_out = (lhs_in[7] == rhs_eff[7]) && (sum[7] != lhs_in[7]);
  // True sign of the result even when it wrapped
  assign signed_out = sum[7] ^ wrap_out;
  assign zero_out = (sum[7:0] == 8'h00);
endmodule
`default_nettype wire

// ===== logic/exec_unit.sv
// Purpose: Executes byte, bit, skip, subtract, table read, xor and far ops
// Assumes: Operand byte arrives with the op; program word one cycle after address
// Notes: One op per free cycle; busy refuses new ops
`timescale 1ns/1ns
`default_nettype none
module exec_unit #(
  parameter int ADDR_W = exec_pkg::DEF_ADDR_W,
  parameter int PC_W = exec_pkg::DEF_PC_W
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic op_valid_in,
  input wire exec_pkg::op_t op_code_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] imm_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [15:0] prog_word_in,
  input wire logic acc_load_in,
  input wire logic [7:0] acc_value_in,
  input wire logic flags_load_in,
  input wire logic [exec_pkg::FLAG_W-1:0] flags_value_in,
  input wire logic ptr_load_in,
  input wire logic [7:0] ptr_low_in,
  input wire logic [PC_W-9:0] ptr_high_in,
  output logic busy_out,
  output logic done_out,
  output logic skip_out,
  output logic [7:0] acc_out,
  output logic [exec_pkg::FLAG_W-1:0] flags_out,
  output logic mem_we_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic prog_re_out,
  output logic [PC_W-1:0] prog_addr_out,
  output logic [7:0] table_high_latch_out,
  output logic [7:0] table_pointer_low_out,
  output logic [PC_W-9:0] table_pointer_high_out
);
  typedef struct packed {
    exec_pkg::st_t st;
    logic busy;
    logic done;
    logic skip;
    logic [7:0] acc;
    logic [exec_pkg::FLAG_W-1:0] flags;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic prog_re;
    logic [PC_W-1:0] prog_addr;
    logic [7:0] tbl_latch;
    logic [7:0] ptr_low;
    logic [PC_W-9:0] ptr_high;
  } state_t;

  state_t q;
  state_t n;
  logic take;
  logic [7:0] bit_mask;
  logic [7:0] inc_val;
  logic [7:0] alu_rhs;
  logic alu_sub;
  logic alu_cin;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_ac;
  logic alu_ov;
  logic alu_sc;
  logic alu_z;

  // New ops are only looked at when the unit is free
  assign take = ce_in && op_valid_in && !q.busy;
  assign bit_mask = exec_pkg::ONE << bit_sel_in;
  assign inc_val = mem_rdata_in + exec_pkg::ONE;
  assign alu_sub = (op_code_in == exec_pkg::OP_SUBTRACT_TO_ACC) ||
                   (op_code_in == exec_pkg::OP_SUBTRACT_INTO_MEM) ||
                   (op_code_in == exec_pkg::OP_SUBTRACT_IMM);
  assign alu_rhs = (op_code_in == exec_pkg::OP_SUBTRACT_IMM) ? imm_in : mem_rdata_in;
  assign alu_cin = ((op_code_in == exec_pkg::OP_FAR_ADD_CARRY_TO_ACC) ||
                    (op_code_in == exec_pkg::OP_FAR_ADD_CARRY_TO_MEM)) &&
                   q.flags[exec_pkg::FLG_CARRY];

  arith_core u_arith (
    .lhs_in(q.acc),
    .rhs_in(alu_rhs),
    .carry_in(alu_cin),
    .subtract_in(alu_sub),
    .result_out(alu_res),
    .carry_out(alu_c),
    .aux_out(alu_ac),
    .wrap_out(alu_ov),
    .signed_out(alu_sc),
    .zero_out(alu_z)
  );

  always_comb begin
    logic skip_c;
    logic [7:0] logic_res;
    logic [7:0] low_next;
    skip_c = 1'b0;
    logic_res = 8'h00;
    low_next = q.ptr_low;
    n = q;
    n.mem_we = 1'b0;
    n.done = 1'b0;
    n.skip = 1'b0;
    n.prog_re = 1'b0;
    if (acc_load_in) begin
      n.acc = acc_value_in;
    end
    if (flags_load_in) begin
      n.flags = flags_value_in;
    end
    if (ptr_load_in) begin
      n.ptr_low = ptr_low_in;
      n.ptr_high = ptr_high_in;
    end
    case (q.st)
      exec_pkg::ST_IDLE: begin
        if (take) begin
          // Full-width address: far ops reach every section
          n.mem_addr = addr_in;
          n.done = 1'b1;
          case (op_code_in)
            exec_pkg::OP_SET_BYTE: begin
              n.mem_we = 1'b1;
              n.mem_wdata = exec_pkg::ALL_ONES;
            end
            exec_pkg::OP_SET_BIT: begin
              n.mem_we = 1'b1;
              n.mem_wdata = mem_rdata_in | bit_mask;
            end
            exec_pkg::OP_FAR_CLEAR_MEM: begin
              n.mem_we = 1'b1;
              n.mem_wdata = exec_pkg::ALL_ZERO;
            end
            exec_pkg::OP_FAR_CLEAR_BIT: begin
              n.mem_we = 1'b1;
              n.mem_wdata = mem_rdata_in & ~bit_mask;
            end
            exec_pkg::OP_INC_SKIP_IF_ZERO: begin
              n.mem_we = 1'b1;
              n.mem_wdata = inc_val;
              skip_c = (inc_val == exec_pkg::ALL_ZERO);
            end
            exec_pkg::OP_INC_TO_ACC_SKIP_IF_ZERO: begin
              n.acc = inc_val;
              skip_c = (inc_val == exec_pkg::ALL_ZERO);
            end
            exec_pkg::OP_BIT_SKIP_IF_NONZERO: begin
              skip_c = |(mem_rdata_in & bit_mask);
            end
            exec_pkg::OP_BIT_SKIP_IF_ZERO: begin
              skip_c = ~|(mem_rdata_in & bit_mask);
            end
            exec_pkg::OP_SKIP_IF_NONZERO: begin
              n.mem_we = 1'b1;
              n.mem_wdata = mem_rdata_in;
              skip_c = (mem_rdata_in != exec_pkg::ALL_ZERO);
            end
            exec_pkg::OP_SKIP_IF_ZERO: begin
              n.mem_we = 1'b1;
              n.mem_wdata = mem_rdata_in;
              skip_c = (mem_rdata_in == exec_pkg::ALL_ZERO);
            end
            exec_pkg::OP_COPY_SKIP_IF_ZERO: begin
              n.acc = mem_rdata_in;
              skip_c = (mem_rdata_in == exec_pkg::ALL_ZERO);
            end
            exec_pkg::OP_SUBTRACT_TO_ACC,
            exec_pkg::OP_SUBTRACT_INTO_MEM,
            exec_pkg::OP_SUBTRACT_IMM: begin
              if (op_code_in == exec_pkg::OP_SUBTRACT_INTO_MEM) begin
                n.mem_we = 1'b1;
                n.mem_wdata = alu_res;
              end else begin
                n.acc = alu_res;
              end
              n.flags[exec_pkg::FLG_CARRY] = alu_c;
              n.flags[exec_pkg::FLG_AUX] = alu_ac;
              n.flags[exec_pkg::FLG_ZERO] = alu_z;
              n.flags[exec_pkg::FLG_WRAP] = alu_ov;
              n.flags[exec_pkg::FLG_SIGNED] = alu_sc;
              // No borrow chain here, so chained zero equals zero
              n.flags[exec_pkg::FLG_CHAIN_ZERO] = alu_z;
            end
            exec_pkg::OP_NIBBLE_EXCHANGE_MEM: begin
              n.mem_we = 1'b1;
              n.mem_wdata = {mem_rdata_in[3:0], mem_rdata_in[7:4]};
            end
            exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: begin
              n.acc = {mem_rdata_in[3:0], mem_rdata_in[7:4]};
            end
            exec_pkg::OP_TABLE_READ_PAGED,
            exec_pkg::OP_TABLE_READ_LAST_PAGE,
            exec_pkg::OP_PREINC_TABLE_READ_PAGED,
            exec_pkg::OP_PREINC_TABLE_READ_LAST: begin
              if ((op_code_in == exec_pkg::OP_PREINC_TABLE_READ_PAGED) ||
                  (op_code_in == exec_pkg::OP_PREINC_TABLE_READ_LAST)) begin
                // Only the low pointer steps; no carry into the high one
                low_next = q.ptr_low + exec_pkg::ONE;
              end
              n.ptr_low = low_next;
              if ((op_code_in == exec_pkg::OP_TABLE_READ_PAGED) ||
                  (op_code_in == exec_pkg::OP_PREINC_TABLE_READ_PAGED)) begin
                n.prog_addr = {q.ptr_high, low_next};
              end else begin
                n.prog_addr = {{(PC_W - 8){1'b1}}, low_next};
              end
              n.prog_re = 1'b1;
              n.done = 1'b0;
              n.busy = 1'b1;
              n.st = exec_pkg::ST_TABLE_FETCH;
            end
            exec_pkg::OP_XOR_TO_ACC,
            exec_pkg::OP_XOR_INTO_MEM,
            exec_pkg::OP_XOR_IMM,
            exec_pkg::OP_FAR_AND_TO_ACC,
            exec_pkg::OP_FAR_AND_TO_MEM: begin
              if ((op_code_in == exec_pkg::OP_FAR_AND_TO_ACC) ||
                  (op_code_in == exec_pkg::OP_FAR_AND_TO_MEM)) begin
                logic_res = q.acc & mem_rdata_in;
              end else begin
                logic_res = q.acc ^ alu_rhs_xor(op_code_in, imm_in, mem_rdata_in);
              end
              if ((op_code_in == exec_pkg::OP_XOR_INTO_MEM) ||
                  (op_code_in == exec_pkg::OP_FAR_AND_TO_MEM)) begin
                n.mem_we = 1'b1;
                n.mem_wdata = logic_res;
              end else begin
                n.acc = logic_res;
              end
              n.flags[exec_pkg::FLG_ZERO] = (logic_res == exec_pkg::ALL_ZERO);
            end
            exec_pkg::OP_FAR_ADD_CARRY_TO_ACC,
            exec_pkg::OP_FAR_ADD_CARRY_TO_MEM,
            exec_pkg::OP_FAR_ADD_TO_ACC,
            exec_pkg::OP_FAR_ADD_TO_MEM: begin
              if ((op_code_in == exec_pkg::OP_FAR_ADD_CARRY_TO_MEM) ||
                  (op_code_in == exec_pkg::OP_FAR_ADD_TO_MEM)) begin
                n.mem_we = 1'b1;
                n.mem_wdata = alu_res;
              end else begin
                n.acc = alu_res;
              end
              // Chained zero is left alone by additions
              n.flags[exec_pkg::FLG_CARRY] = alu_c;
              n.flags[exec_pkg::FLG_AUX] = alu_ac;
              n.flags[exec_pkg::FLG_ZERO] = alu_z;
              n.flags[exec_pkg::FLG_WRAP] = alu_ov;
              n.flags[exec_pkg::FLG_SIGNED] = alu_sc;
            end
            default: begin
              n.done = 1'b1;
            end
          endcase
          if (skip_c) begin
            n.skip = 1'b1;
            n.busy = 1'b1;
            n.st = exec_pkg::ST_DUMMY;
          end
        end
      end
      exec_pkg::ST_DUMMY: begin
        // Dummy slot while the next op is fetched
        n.busy = 1'b0;
        n.st = exec_pkg::ST_IDLE;
      end
      exec_pkg::ST_TABLE_FETCH: begin
        n.mem_we = 1'b1;
        n.mem_wdata = prog_word_in[7:0];
        n.tbl_latch = prog_word_in[15:8];
        n.done = 1'b1;
        n.busy = 1'b0;
        n.st = exec_pkg::ST_IDLE;
      end
      default: begin
        n.st = exec_pkg::ST_IDLE;
        n.busy = 1'b0;
      end
    endcase
  end

  // Immediate only for the immediate xor form
  function automatic logic [7:0] alu_rhs_xor(input exec_pkg::op_t op, input logic [7:0] imm,
                                             input logic [7:0] mem);
    alu_rhs_xor = (op == exec_pkg::OP_XOR_IMM) ? imm : mem;
  endfunction

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= n;
    end
  end

  assign busy_out = q.busy;
  assign done_out = q.done;
  assign skip_out = q.skip;
  assign acc_out = q.acc;
  assign flags_out = q.flags;
  assign mem_we_out = q.mem_we;
  assign mem_addr_out = q.mem_addr;
  assign mem_wdata_out = q.mem_wdata;
  assign prog_re_out = q.prog_re;
  assign prog_addr_out = q.prog_addr;
  assign table_high_latch_out = q.tbl_latch;
  assign table_pointer_low_out = q.ptr_low;
  assign table_pointer_high_out = q.ptr_high;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence took(exec_pkg::op_t o);
    take && (op_code_in == o) && !acc_load_in && !flags_load_in;
  endsequence

  sequence dummy_slot;
    busy_out && skip_out ##1 !busy_out;
  endsequence

  sequence fetch_then_store;
    prog_re_out && busy_out ##1 mem_we_out && done_out && !busy_out;
  endsequence

  a_set_byte_ones: assert property (took(exec_pkg::OP_SET_BYTE) |=>
    mem_we_out && mem_wdata_out == 8'hff && flags_out == $past(flags_out))
    else $error("byte set wrong");
  a_set_bit_only: assert property (took(exec_pkg::OP_SET_BIT) |=>
    mem_wdata_out == ($past(mem_rdata_in) | $past(bit_mask)) && flags_out == $past(flags_out))
    else $error("bit set wrong");
  a_far_clear_zero: assert property (took(exec_pkg::OP_FAR_CLEAR_MEM) |=>
    mem_we_out && mem_wdata_out == 8'h00 && mem_addr_out == $past(addr_in))
    else $error("far clear wrong");
  a_inc_skip_zero: assert property (took(exec_pkg::OP_INC_SKIP_IF_ZERO) |=>
    mem_wdata_out == 8'($past(mem_rdata_in) + 8'h01) && skip_out == (mem_wdata_out == 8'h00))
    else $error("increment skip wrong");
  a_inc_acc_keep: assert property (took(exec_pkg::OP_INC_TO_ACC_SKIP_IF_ZERO) |=>
    !mem_we_out && acc_out == 8'($past(mem_rdata_in) + 8'h01))
    else $error("increment to acc wrong");
  a_bit_test_skip: assert property (took(exec_pkg::OP_BIT_SKIP_IF_ZERO) |=>
    skip_out == (($past(mem_rdata_in) & $past(bit_mask)) == 8'h00) && !mem_we_out)
    else $error("bit test skip wrong");
  a_copy_skip_acc: assert property (took(exec_pkg::OP_COPY_SKIP_IF_ZERO) |=>
    acc_out == $past(mem_rdata_in) && skip_out == (acc_out == 8'h00))
    else $error("copy skip wrong");
  a_skip_two_cycles: assert property (skip_out && ce_in |-> dummy_slot)
    else $error("skip dummy slot wrong");
  a_sub_carry_sense: assert property (took(exec_pkg::OP_SUBTRACT_TO_ACC) |=>
    flags_out[exec_pkg::FLG_CARRY] == ($past(acc_out) >= $past(mem_rdata_in)) &&
    acc_out == 8'($past(acc_out) - $past(mem_rdata_in)))
    else $error("subtract wrong");
  a_swap_nibbles: assert property (took(exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC) |=>
    acc_out == {$past(mem_rdata_in[3:0]), $past(mem_rdata_in[7:4])} && !mem_we_out)
    else $error("nibble exchange wrong");
  a_table_paged_store: assert property (take && !ptr_load_in &&
    op_code_in == exec_pkg::OP_TABLE_READ_PAGED |=> fetch_then_store)
    else $error("table read sequence wrong");
  a_xor_zero_only: assert property (took(exec_pkg::OP_XOR_TO_ACC) |=>
    flags_out[5:3] == $past(flags_out[5:3]) && flags_out[1:0] == $past(flags_out[1:0]))
    else $error("xor touched other flags");
endmodule
`default_nettype wire

// ===== sim/far_memory_model.sv
// Purpose: Data and program memory stand-in for the execution unit
// Assumes: Data reads are combinational; writes land on the clock edge while the write strobe is high
// Notes: Program bus shows the inverted word when not read, so stale sampling fails
`timescale 1ns/1ns
`default_nettype none
module far_memory_model #(
  parameter int ADDR_W = 9,
  parameter int PC_W = 13
) (
  input wire logic clk_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  input wire logic we_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  input wire logic prog_re_in,
  input wire logic [PC_W-1:0] prog_addr_in,
  output logic [15:0] prog_word_out
);
  logic [7:0] mem_q [2**ADDR_W];
  logic [15:0] word;
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) mem_q[i] = 8'(i) ^ 8'ha5;
  end
  always @(posedge clk_in) begin
    if (we_in) mem_q[wr_addr_in] <= wr_data_in;
  end
  // A byte written on this edge is what a back-to-back op must read
  assign rd_data_out = (we_in && (wr_addr_in == rd_addr_in)) ? wr_data_in : mem_q[rd_addr_in];
  // Low byte mixes in page bits so a wrong page shows up
  assign word = {prog_addr_in[7:0] ^ 8'h3c, 8'(prog_addr_in[PC_W-1:8]) ^ prog_addr_in[7:0]};
  assign prog_word_out = prog_re_in ? word : ~word;
endmodule
`default_nettype wire

// ===== sim/mcu_exec_unit_s_to_x_and_far_ops_bench.sv
// Purpose: Self-checking bench comparing exec_unit with a reference model
// Assumes: Memory stand-in starts with index xor a5 in every byte
// Notes: Small address pool so skips and wraps recur
`timescale 1ns/1ns
`default_nettype none
module mcu_exec_unit_s_to_x_and_far_ops_bench;
  localparam int AW = 9;
  localparam int PW = 13;
  localparam int LIMIT = 20000;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ce_in = 1'b1;
  logic op_valid_in = 1'b0;
  exec_pkg::op_t op_code_in = exec_pkg::OP_NONE;
  logic [AW-1:0] addr_in = '0;
  logic [2:0] bit_sel_in = '0;
  logic [7:0] imm_in = '0;
  logic acc_load_in = 1'b0;
  logic flags_load_in = 1'b0;
  logic ptr_load_in = 1'b0;
  logic [7:0] acc_value_in = '0;
  logic [5:0] flags_value_in = '0;
  logic [7:0] ptr_low_in = '0;
  logic [PW-9:0] ptr_high_in = '0;
  logic [7:0] mem_rdata_in, acc_out, mem_wdata_out, table_high_latch_out, table_pointer_low_out;
  logic [15:0] prog_word_in;
  logic busy_out, done_out, skip_out, mem_we_out, prog_re_out;
  logic [5:0] flags_out;
  logic [AW-1:0] mem_addr_out;
  logic [PW-1:0] prog_addr_out;
  logic [PW-9:0] table_pointer_high_out;
  logic [7:0] acc, plo, lat;
  logic [7:0] mirror [2**AW];
  logic [5:0] flg;
  logic [PW-9:0] phi;
  logic [31:0] seed = 32'he009;
  int fails = 0;
  int checked = 0;
  int cycles = 0;

  exec_unit #(.ADDR_W(AW), .PC_W(PW)) u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .ce_in(ce_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in), .addr_in(addr_in),
    .bit_sel_in(bit_sel_in), .imm_in(imm_in), .mem_rdata_in(mem_rdata_in),
    .prog_word_in(prog_word_in), .acc_load_in(acc_load_in), .acc_value_in(acc_value_in),
    .flags_load_in(flags_load_in), .flags_value_in(flags_value_in), .ptr_load_in(ptr_load_in),
    .ptr_low_in(ptr_low_in), .ptr_high_in(ptr_high_in), .busy_out(busy_out),
    .done_out(done_out), .skip_out(skip_out), .acc_out(acc_out), .flags_out(flags_out),
    .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .prog_re_out(prog_re_out), .prog_addr_out(prog_addr_out),
    .table_high_latch_out(table_high_latch_out), .table_pointer_low_out(table_pointer_low_out),
    .table_pointer_high_out(table_pointer_high_out));

  far_memory_model #(.ADDR_W(AW), .PC_W(PW)) u_mem (.clk_in(clk_in), .rd_addr_in(addr_in),
    .we_in(mem_we_out), .wr_addr_in(mem_addr_out), .wr_data_in(mem_wdata_out),
    .rd_data_out(mem_rdata_in), .prog_re_in(prog_re_out), .prog_addr_in(prog_addr_out),
    .prog_word_out(prog_word_in));

  always #5 clk_in = ~clk_in;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction

  // Returns {signed, wrap, aux, carry, sum}; subtract passes inverted operand, carry 1
  function automatic logic [11:0] arith(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    logic ov;
    s = {1'b0, a} + {1'b0, b} + 9'(cin);
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin);
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    return {s[7] ^ ov, ov, h[4], s[8], s[7:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_free();
    for (int n = 0; n < 8 && busy_out !== 1'b0; n++) begin
      @(posedge clk_in);
      #1;
    end
  endtask

  task automatic load(input logic [7:0] a, input logic [5:0] f, input logic [7:0] pl,
                      input logic [PW-9:0] ph);
    wait_free();
    op_valid_in = 1'b0;
    {acc_load_in, flags_load_in, ptr_load_in} = 3'b111;
    {acc_value_in, flags_value_in, ptr_low_in, ptr_high_in} = {a, f, pl, ph};
    @(posedge clk_in);
    #1;
    {acc_load_in, flags_load_in, ptr_load_in} = 3'b000;
    {acc, flg, plo, phi} = {a, f, pl, ph};
    chk(32'({acc_out, flags_out, table_pointer_low_out, table_pointer_high_out}),
        32'({a, f, pl, ph}));
  endtask

  // Offer an op that must be ignored: while busy, or with the clock enable low
  task automatic ignored(input logic ce);
    ce_in = ce;
    op_valid_in = 1'b1;
    op_code_in = exec_pkg::OP_SET_BYTE;
    addr_in = 9'h002;
    repeat (ce ? 1 : 3) @(posedge clk_in);
    #1;
    op_valid_in = 1'b0;
    ce_in = 1'b1;
    @(posedge clk_in);
    #1;
    chk(32'({done_out, mem_we_out}), 32'h0);
  endtask

  task automatic run(input exec_pkg::op_t op, input logic [AW-1:0] ad,
                     input logic [2:0] bs, input logic [7:0] im);
    logic [7:0] m, res;
    logic [11:0] ar;
    logic [1:0] dst;
    logic sk, tab;
    logic [PW-1:0] pa;
    logic [15:0] wd;
    wait_free();
    m = mirror[ad];
    {res, dst, sk, tab} = '0;
    {op_valid_in, op_code_in, addr_in, bit_sel_in, imm_in} = {1'b1, op, ad, bs, im};
    @(posedge clk_in);
    #1;
    // Valid stays up until the next call replaces or drops it
    case (op)
      exec_pkg::OP_SET_BYTE: {dst, res} = {2'd2, 8'hff};
      exec_pkg::OP_SET_BIT: {dst, res} = {2'd2, m | (8'h01 << bs)};
      exec_pkg::OP_FAR_CLEAR_MEM: {dst, res} = {2'd2, 8'h00};
      exec_pkg::OP_FAR_CLEAR_BIT: {dst, res} = {2'd2, m & ~(8'h01 << bs)};
      exec_pkg::OP_INC_SKIP_IF_ZERO: {dst, res, sk} = {2'd2, m + 8'h01, m == 8'hff};
      exec_pkg::OP_INC_TO_ACC_SKIP_IF_ZERO: {dst, res, sk} = {2'd1, m + 8'h01, m == 8'hff};
      exec_pkg::OP_BIT_SKIP_IF_NONZERO: sk = m[bs];
      exec_pkg::OP_BIT_SKIP_IF_ZERO: sk = !m[bs];
      exec_pkg::OP_SKIP_IF_NONZERO: {dst, res, sk} = {2'd2, m, m != 8'h00};
      exec_pkg::OP_SKIP_IF_ZERO: {dst, res, sk} = {2'd2, m, m == 8'h00};
      exec_pkg::OP_COPY_SKIP_IF_ZERO: {dst, res, sk} = {2'd1, m, m == 8'h00};
      exec_pkg::OP_SUBTRACT_TO_ACC, exec_pkg::OP_SUBTRACT_INTO_MEM,
      exec_pkg::OP_SUBTRACT_IMM: begin
        ar = arith(acc, ~((op == exec_pkg::OP_SUBTRACT_IMM) ? im : m), 1'b1);
        flg = {ar[7:0] == 0, ar[11:10], ar[7:0] == 0, ar[9:8]};
        {dst, res} = {(op == exec_pkg::OP_SUBTRACT_INTO_MEM) ? 2'd2 : 2'd1, ar[7:0]};
      end
      exec_pkg::OP_NIBBLE_EXCHANGE_MEM: {dst, res} = {2'd2, m[3:0], m[7:4]};
      exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: {dst, res} = {2'd1, m[3:0], m[7:4]};
      exec_pkg::OP_XOR_TO_ACC, exec_pkg::OP_XOR_INTO_MEM, exec_pkg::OP_XOR_IMM: begin
        res = acc ^ ((op == exec_pkg::OP_XOR_IMM) ? im : m);
        flg[2] = (res == 0);
        dst = (op == exec_pkg::OP_XOR_INTO_MEM) ? 2'd2 : 2'd1;
      end
      exec_pkg::OP_FAR_ADD_CARRY_TO_ACC, exec_pkg::OP_FAR_ADD_CARRY_TO_MEM,
      exec_pkg::OP_FAR_ADD_TO_ACC, exec_pkg::OP_FAR_ADD_TO_MEM: begin
        ar = arith(acc, m, (op < exec_pkg::OP_FAR_ADD_TO_ACC) ? flg[0] : 1'b0);
        flg[4:0] = {ar[11:10], ar[7:0] == 0, ar[9:8]};
        res = ar[7:0];
        dst = (op == exec_pkg::OP_FAR_ADD_CARRY_TO_MEM || op == exec_pkg::OP_FAR_ADD_TO_MEM) ?
              2'd2 : 2'd1;
      end
      exec_pkg::OP_FAR_AND_TO_ACC, exec_pkg::OP_FAR_AND_TO_MEM: begin
        res = acc & m;
        flg[2] = (res == 0);
        dst = (op == exec_pkg::OP_FAR_AND_TO_MEM) ? 2'd2 : 2'd1;
      end
      default: begin
        tab = 1'b1;
        if (op >= exec_pkg::OP_PREINC_TABLE_READ_PAGED) plo = plo + 8'h01;
        pa = (op == exec_pkg::OP_TABLE_READ_PAGED || op == exec_pkg::OP_PREINC_TABLE_READ_PAGED)
             ? {phi, plo} : {{(PW-8){1'b1}}, plo};
        wd = {pa[7:0] ^ 8'h3c, 8'(pa[PW-1:8]) ^ pa[7:0]};
        {dst, res, lat} = {2'd2, wd[7:0], wd[15:8]};
        chk(32'({prog_re_out, busy_out, prog_addr_out, table_pointer_low_out}),
            32'({2'b11, pa, plo}));
        @(posedge clk_in);
        #1;
      end
    endcase
    if (dst == 2'd1) acc = res;
    chk(32'({done_out, skip_out, busy_out, mem_we_out}), 32'({1'b1, sk, sk, dst == 2'd2}));
    if (dst == 2'd2) chk(32'({mem_addr_out, mem_wdata_out}), 32'({ad, res}));
    chk(32'({acc_out, flags_out, table_high_latch_out}), 32'({acc, flg, lat}));
    if (dst == 2'd2) mirror[ad] = res;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      conclude();
    end
  end

  initial begin
    {acc, flg, plo, phi, lat} = '0;
    for (int i = 0; i < 2**AW; i++) mirror[i] = 8'(i) ^ 8'ha5;
    repeat (12) @(posedge clk_in);
    #1;
    chk(32'({acc_out, flags_out, done_out, mem_we_out, busy_out, prog_re_out}), 32'h0);
    resetn_in = 1'b1;
    // Pointer wrap must not carry into the page bits
    load(8'h7f, 6'h00, 8'hff, 5'h05);
    run(exec_pkg::OP_PREINC_TABLE_READ_PAGED, 9'h1ff, 3'd0, 8'h00);
    run(exec_pkg::OP_SET_BYTE, 9'h1ff, 3'd0, 8'h00);
    run(exec_pkg::OP_INC_SKIP_IF_ZERO, 9'h1ff, 3'd0, 8'h00);
    ignored(1'b1);
    ignored(1'b0);
    run(exec_pkg::OP_SUBTRACT_IMM, 9'h000, 3'd0, 8'h80);
    repeat (600) begin
      seed = lfsr(seed);
      if (seed[2:0] == 3'd0) load(seed[15:8], seed[21:16], seed[31:24], seed[7:3]);
      seed = lfsr(seed);
      run(exec_pkg::op_t'(5'((seed[4:0] % 5'd29) + 5'd1)), {seed[5], 6'h00, seed[7:6]},
          seed[10:8], seed[18:11]);
    end
    wait_free();
    conclude();
  end
endmodule
`default_nettype wire
